// ==== shared/alf_pkg.sv ====
package alf_pkg;
    // Register map, byte addresses
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] STAT_OFF = 4'h4;
    // Bus responses
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Control register layout, bit 0 is dual
    typedef struct packed {
        logic spd;   // Software power-down
        logic xlat;  // One extra output cycle
        logic fmt;   // Output format select
        logic dual;  // Dual-lane mode
    } alf_ctrl_t;
    localparam alf_ctrl_t CTRL_RST = 4'h0;

    // Lane symbols, first transmitted bit at bit 0
    typedef struct packed {
        logic [9:0] sym1;
        logic [9:0] sym0;
    } alf_lanes_t;

    // Sample geometry
    localparam int SAMPLE_W = 14;
    localparam int PAD_BITS = 4;

    // Latencies in conversion clocks
    localparam int PIPE_LAT     = 20;
    localparam int SYNC_ON_LAT  = 9;
    localparam int SYNC_OFF_LAT = 8;

    // Wake-up times in microseconds and cycles
    localparam int CLK_MHZ      = 50;
    localparam int WAKE_FULL_US = 50;
    localparam int WAKE_FAST_US = 50;
    localparam int WAKE_SOFT_US = 10;
    localparam int WAKE_CLK_US  = 5;
    localparam logic [11:0] WAKE_FULL_CYC = 12'(WAKE_FULL_US * CLK_MHZ);
    localparam logic [11:0] WAKE_FAST_CYC = 12'(WAKE_FAST_US * CLK_MHZ);
    localparam logic [11:0] WAKE_SOFT_CYC = 12'(WAKE_SOFT_US * CLK_MHZ);
    localparam logic [11:0] WAKE_CLK_CYC  = 12'(WAKE_CLK_US * CLK_MHZ);

    // 5b/6b and 3b/4b codes for negative disparity, a and f leftmost
    localparam logic [0:31][5:0] T56 = {
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [0:7][3:0] T34 = {
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    localparam logic [3:0] ALT7 = 4'h7;
    // Comma character for negative disparity, a leftmost
    localparam logic [9:0] K285 = 10'h0fa;
endpackage : alf_pkg

// ==== rtl/alf_framer.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: Pad each 14-bit sample with four zero bits below the LSB.
// RQ2: First octet is the top eight bits, second the rest plus padding.
// RQ3: Single lane sends both octets in turn; dual lane one octet each.
// RQ4: Single-lane mode is selected after reset.
// RQ5: A sample reaches the output 20 clocks after it is taken.
// RQ6: Extra latency option adds one more output cycle.
// RQ7: Receiver pulls the sync request low to ask for realignment.
// RQ8: While sync is requested every lane sends K28.5; in single-lane mode lane 1 is held low instead.
// RQ9: Both sync edges are latched on the internal clock.
// RQ10: K28.5 appears 9 clocks after the request is latched.
// RQ11: Data resumes 8 clocks after the release is latched.
// RQ12: Data valid typically 50 us after complete power-down.
// RQ13: Data valid typically 50 us after fast-recovery power-down.
// RQ14: Data valid typically 10 us after software power-down.
// RQ15: Data valid typically 5 us after the clock restarts.
// RQ16: Format select clear gives twos complement, set gives offset binary.
// RQ17: Octets are 8b10b coded per lane, first bit leading.
// RQ18: Single-lane data resumes with the most significant octet.
module alf_framer #(
    parameter int LATENCY = alf_pkg::PIPE_LAT
) (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Converter core, offset binary
    input  wire logic [13:0]         sample_in,
    // Pins
    input  wire logic                sync_req_n,
    input  wire logic                pdn_full,
    input  wire logic                pdn_fast,
    // Link side
    output var  alf_pkg::alf_lanes_t lane_sym,
    output var  logic                lane1_on,
    output var  logic                sample_sent,
    output var  logic                data_valid
);

    typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_WAKE} alf_pwr_t;

    alf_pkg::alf_ctrl_t ctrl_reg;
    alf_pwr_t           pwr_reg;
    logic               aw_got;
    logic               w_got;
    logic [3:0]         waddr_reg;
    logic [7:0]         wdata_reg;
    logic               wstrb0_reg;
    logic               wr_fire;
    logic               wr_hit;
    logic               sync_meta;
    logic               sync_sync;
    logic [1:0]         pd_meta;
    logic [1:0]         pd_sync;
    logic               act;
    logic [7:0]         act_dly;
    logic               k_sel;
    logic               k_reg;
    logic               slot_reg;
    logic [7:0]         lsb_hold_reg;
    logic [13:0]        dl [0:LATENCY];
    logic [13:0]        tap;
    logic [15:0]        word;
    logic [alf_pkg::SAMPLE_W+alf_pkg::PAD_BITS-1:0] padded;
    logic [7:0]         oct [2];
    logic               rd_reg [2];
    logic [9:0]         sym_reg [2];
    logic [7:0]         out_oct_reg [2];
    logic               pd_any;
    logic [11:0]        wake_cnt_reg;
    logic [11:0]        wake_age;
    logic [4:0]         cfg_age;

    // 8b10b encode, returns new disparity and symbol with bit a at 0
    function automatic logic [10:0] enc(input logic [7:0] d,
                                        input logic       k,
                                        input logic       rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       r6;
        logic [9:0] w;
        logic [9:0] wr;
        s6 = alf_pkg::T56[d[4:0]];
        if (rd && ($countones(s6) != 3 || s6 == 6'h38)) begin
            s6 = ~s6;
        end
        r6 = rd ^ ($countones(s6) != 3);
        s4 = alf_pkg::T34[d[7:5]];
        if (d[7:5] == 3'h7 && (r6 ? s6[1:0] == 2'h0 : s6[1:0] == 2'h3)) begin
            s4 = alf_pkg::ALT7; // Avoid a run of five
        end
        if (r6 && ($countones(s4) != 2 || d[7:5] == 3'h3)) begin
            s4 = ~s4;
        end
        w = k ? (rd ? ~alf_pkg::K285 : alf_pkg::K285) : {s6, s4};
        for (int i = 0; i < 10; i++) begin
            wr[i] = w[9 - i];
        end
        enc = {k ? ~rd : r6 ^ ($countones(s4) != 2), wr};
    endfunction : enc

    // Write address and data are taken in either order
    assign wr_fire = aw_got && w_got && !s_axi_bvalid;
    assign wr_hit  = waddr_reg == alf_pkg::CTRL_OFF;

    // Write channel handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= alf_pkg::RESP_OK;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            waddr_reg     <= 4'h0;
            wdata_reg     <= 8'h00;
            wstrb0_reg    <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                s_axi_awready <= 1'b0;
                waddr_reg     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata[7:0];
                wstrb0_reg   <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? alf_pkg::RESP_OK : alf_pkg::RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control register, dual lane off after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= alf_pkg::CTRL_RST; // [RQ4]
        end else if (wr_fire && wr_hit && wstrb0_reg) begin
            ctrl_reg <= alf_pkg::alf_ctrl_t'(wdata_reg[3:0]);
        end
    end

    // Read channel, status shows live block state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= alf_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= alf_pkg::RESP_OK;
            case (s_axi_araddr)
                alf_pkg::CTRL_OFF: begin
                    s_axi_rdata <= {28'h0, ctrl_reg};
                end
                alf_pkg::STAT_OFF: begin
                    s_axi_rdata <= {28'h0, pd_any, data_valid, k_reg, act};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= alf_pkg::RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_meta <= 1'b1;
            sync_sync <= 1'b1;
            pd_meta   <= 2'h0;
            pd_sync   <= 2'h0;
        end else begin
            sync_meta <= sync_req_n;
            sync_sync <= sync_meta; // [RQ9]
            pd_meta   <= {pdn_fast, pdn_full};
            pd_sync   <= pd_meta;
        end
    end

    assign act = !sync_sync;

    // Request history sets comma on and off times
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_dly <= 8'h00;
        end else begin
            act_dly <= {act_dly[6:0], act};
        end
    end

    // Comma from 9 clocks after assert until 8 after release
    assign k_sel = act_dly[alf_pkg::SYNC_ON_LAT - 2]
                && act_dly[alf_pkg::SYNC_OFF_LAT - 2]; // [RQ10] [RQ11]

    // Sample pipeline
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i <= LATENCY; i++) begin
                dl[i] <= 14'h0;
            end
        end else begin
            dl[0] <= sample_in;
            for (int i = 1; i <= LATENCY; i++) begin
                dl[i] <= dl[i - 1];
            end
        end
    end

    // Output tap, format and padding
    always_comb begin
        tap  = ctrl_reg.xlat ? dl[LATENCY] : dl[LATENCY - 1]; // [RQ5] [RQ6]
        padded = {ctrl_reg.fmt ? tap[13] : !tap[13], tap[12:0],
                  alf_pkg::PAD_BITS'(0)}; // [RQ1] [RQ16]
        word   = padded[$bits(padded) - 1 -: 16]; // Top 16 bits, two pad zeros kept
        oct[0] = (ctrl_reg.dual || !slot_reg) ? word[15:8] : lsb_hold_reg; // [RQ2]
        oct[1] = word[7:0]; // [RQ2]
    end

    // Octet slot sequencing for the single lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            k_reg        <= 1'b0;
            slot_reg     <= 1'b0;
            lsb_hold_reg <= 8'h00;
            sample_sent  <= 1'b0;
            lane1_on     <= 1'b0;
        end else begin
            k_reg       <= k_sel;
            sample_sent <= !k_sel && (ctrl_reg.dual || !slot_reg);
            lane1_on    <= ctrl_reg.dual;
            if (k_sel || ctrl_reg.dual) begin
                slot_reg <= 1'b0; // [RQ18]
            end else begin
                slot_reg <= !slot_reg; // [RQ3]
            end
            if (!slot_reg) begin
                lsb_hold_reg <= word[7:0];
            end
        end
    end

    // Per-lane encoder and disparity
    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic [10:0] code;
        always_comb begin
            code = enc(oct[g], k_sel, rd_reg[g]); // [RQ8] [RQ17]
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rd_reg[g]      <= 1'b0;
                sym_reg[g]     <= 10'h0;
                out_oct_reg[g] <= 8'h00;
            end else if (g == 0 || ctrl_reg.dual) begin
                rd_reg[g]      <= code[10];
                sym_reg[g]     <= code[9:0];
                out_oct_reg[g] <= oct[g];
            end else begin
                sym_reg[g]     <= 10'h0; // Idle lane held low
            end
        end
    end

    assign lane_sym = '{sym1: sym_reg[1], sym0: sym_reg[0]};

    assign pd_any = pd_sync[0] || pd_sync[1] || ctrl_reg.spd;

    // Power state and wake-up timer, reset counts as clock restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_reg      <= ST_WAKE;
            wake_cnt_reg <= alf_pkg::WAKE_CLK_CYC; // [RQ15]
            data_valid   <= 1'b0;
        end else begin
            case (pwr_reg)
                ST_RUN: begin
                    wake_cnt_reg <= alf_pkg::WAKE_SOFT_CYC; // Sane count for a short pulse
                    if (pd_any) begin
                        pwr_reg    <= ST_DOWN;
                        data_valid <= 1'b0;
                    end
                end
                ST_DOWN: begin
                    // Cause is picked while still down; on release every cause reads clear
                    if (!pd_any) begin
                        pwr_reg <= ST_WAKE;
                    end else if (pd_sync[0]) begin
                        wake_cnt_reg <= alf_pkg::WAKE_FULL_CYC; // [RQ12]
                    end else if (pd_sync[1]) begin
                        wake_cnt_reg <= alf_pkg::WAKE_FAST_CYC; // [RQ13]
                    end else begin
                        wake_cnt_reg <= alf_pkg::WAKE_SOFT_CYC; // [RQ14]
                    end
                end
                ST_WAKE: begin
                    wake_cnt_reg <= wake_cnt_reg - 12'h1;
                    if (pd_any) begin
                        pwr_reg <= ST_DOWN;
                    end else if (wake_cnt_reg == 12'h1) begin
                        pwr_reg    <= ST_RUN;
                        data_valid <= 1'b1;
                    end
                end
                default: begin
                    pwr_reg <= ST_DOWN;
                end
            endcase
        end
    end

    // Checking helpers: wake time and settle time after a control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_age <= 12'h0;
            cfg_age  <= 5'h0;
        end else begin
            wake_age <= (pwr_reg == ST_WAKE) ? wake_age + 12'h1 : 12'h0;
            if (wr_fire && wr_hit) begin
                cfg_age <= 5'h0;
            end else if (cfg_age != 5'h1f) begin
                cfg_age <= cfg_age + 5'h1;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_single_lane: assert property ($rose(aresetn) |-> !ctrl_reg.dual) // [RQ4]
        else $error("dual lane selected after reset");

    a_pipe_latency: assert property ( // [RQ5] [RQ16]
        cfg_age == 5'h1f && ctrl_reg.dual && !ctrl_reg.xlat && !k_reg
        |-> out_oct_reg[0] == {ctrl_reg.fmt ^ !$past(sample_in[13], 21),
                               $past(sample_in[12:6], 21)})
        else $error("lane 0 octet not the sample from 20 clocks before");

    a_extra_latency: assert property ( // [RQ6]
        cfg_age == 5'h1f && ctrl_reg.dual && ctrl_reg.xlat && !k_reg
        |-> out_oct_reg[0][6:0] == $past(sample_in[12:6], 22))
        else $error("extra latency not one cycle");

    a_pad_zero: assert property ( // [RQ1] [RQ2]
        cfg_age == 5'h1f && ctrl_reg.dual && !ctrl_reg.xlat && !k_reg
        |-> out_oct_reg[1] == {$past(sample_in[5:0], 21), 2'h0})
        else $error("second octet not low bits plus two zeros");

    a_sync_on_lat: assert property ( // [RQ10]
        $rose(act) && !k_reg |-> !k_reg[*8] ##1 !k_reg ##1 k_reg)
        else $error("comma not started 9 clocks after request");

    a_sync_off_lat: assert property ( // [RQ11]
        $fell(act) && k_reg |-> k_reg[*8] ##1 !k_reg)
        else $error("data not resumed 8 clocks after release");

    a_comma_char: assert property ( // [RQ8]
        k_reg |-> lane_sym.sym0 == 10'h17c || lane_sym.sym0 == 10'h283)
        else $error("lane 0 not sending K28.5 during sync");

    a_single_msb_first: assert property ( // [RQ18]
        !ctrl_reg.dual && $fell(k_reg) |-> slot_reg && sample_sent)
        else $error("single lane did not resume on the high octet");

    a_single_alternate: assert property ( // [RQ3]
        cfg_age == 5'h1f && !ctrl_reg.dual && !k_reg && $past(!k_reg)
        |-> slot_reg != $past(slot_reg))
        else $error("single lane octets not alternating");

    a_wake_time: assert property ( // [RQ12] [RQ13] [RQ14] [RQ15]
        $rose(data_valid) |-> wake_age == alf_pkg::WAKE_FULL_CYC
            || wake_age == alf_pkg::WAKE_SOFT_CYC
            || wake_age == alf_pkg::WAKE_CLK_CYC)
        else $error("wake-up time off the documented figure");

    c_sync_comma: cover property ($rose(k_reg) ##[1:20] $fell(k_reg));
    c_dual_data: cover property (ctrl_reg.dual && sample_sent [*4]);
    c_wake_done: cover property ($fell(data_valid) ##[1:1000] pwr_reg == ST_WAKE);

endmodule : alf_framer
`default_nettype wire

// ==== verif/alf_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module alf_rx_model (
    // Request from the bench
    input  wire logic                sync_ask,
    // Lanes from the device
    input  wire alf_pkg::alf_lanes_t lane_sym,
    // Receiver view
    output logic                     sync_req_n,
    output logic [7:0]               byte0,
    output logic [7:0]               byte1,
    output logic                     comma0,
    output logic                     comma1
);
    // Decode a symbol, bit a at bit 0; an exact code wins over its complement
    function automatic logic [7:0] dec(input logic [9:0] s);
        logic [5:0] c6;
        logic [3:0] c4;
        logic [7:0] r;
        c6 = {s[0], s[1], s[2], s[3], s[4], s[5]};
        c4 = {s[6], s[7], s[8], s[9]};
        r  = 8'h00;
        for (int i = 0; i < 32; i++) begin
            if (alf_pkg::T56[i] == ~c6) r[4:0] = 5'(i);
        end
        for (int i = 0; i < 32; i++) begin
            if (alf_pkg::T56[i] == c6) r[4:0] = 5'(i);
        end
        for (int i = 0; i < 8; i++) begin
            if (alf_pkg::T34[i] == ~c4) r[7:5] = 3'(i);
        end
        for (int i = 0; i < 8; i++) begin
            if (alf_pkg::T34[i] == c4) r[7:5] = 3'(i);
        end
        if (c4 == alf_pkg::ALT7 || c4 == ~alf_pkg::ALT7) r[7:5] = 3'h7;
        return r;
    endfunction : dec

    // Active low request whenever realignment is wanted
    assign sync_req_n = ~sync_ask;
    // Octets and comma detection per lane
    assign byte0  = dec(lane_sym.sym0);
    assign byte1  = dec(lane_sym.sym1);
    assign comma0 = lane_sym.sym0 == 10'h17c || lane_sym.sym0 == 10'h283;
    assign comma1 = lane_sym.sym1 == 10'h17c || lane_sym.sym1 == 10'h283;
endmodule : alf_rx_model
`default_nettype wire

// ==== verif/alf_framer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module alf_framer_tb;
    typedef struct packed {
        logic [31:0] cyc;
        logic [13:0] s;
    } alf_note_t;
    // Design inputs
    logic aclk, aresetn, awvalid, wvalid, arvalid, sync_ask, pdn_full, pdn_fast;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [13:0] sample_in;
    // Design outputs and receiver view
    logic awready, wready, bvalid, arready, rvalid, lane1_on, sample_sent, data_valid;
    logic sync_req_n, comma0, comma1;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  byte0, byte1;
    alf_pkg::alf_lanes_t lane_sym;
    // Bench state
    int          fail_count = 0;
    int          checks_done = 0;
    logic [31:0] cyc = 32'h0, v = 32'h0001600e, lat = 32'd20, w, lo_exp, d;
    logic        watch = 1'b0, fmt = 1'b0, dual = 1'b0, lo_due = 1'b0;
    logic [1:0]  r;
    int          n;
    alf_note_t   notes[$];
    alf_note_t   nt;

    alf_framer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .sample_in(sample_in), .sync_req_n(sync_req_n),
        .pdn_full(pdn_full), .pdn_fast(pdn_fast), .lane_sym(lane_sym),
        .lane1_on(lane1_on), .sample_sent(sample_sent), .data_valid(data_valid));
    alf_rx_model rx (.sync_ask(sync_ask), .lane_sym(lane_sym), .sync_req_n(sync_req_n),
        .byte0(byte0), .byte1(byte1), .comma0(comma0), .comma1(comma1));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // Bus write, both channels offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] dd, output logic [1:0] rr);
        logic aw_done, w_done;
        awaddr  <= a;
        wdata   <= dd;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rr = bresp;
    endtask : axi_wr

    // Bus read
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] dd, output logic [1:0] rr);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        dd = rdata;
        rr = rresp;
    endtask : axi_rd

    // New mode, let the pipe flush, then watch the stream
    task automatic set_ctrl(input logic [3:0] c);
        watch = 1'b0;
        axi_wr(alf_pkg::CTRL_OFF, 32'(c), r);
        check("ctrl resp", 32'(r), 32'(alf_pkg::RESP_OK));
        fmt = c[1];
        dual = c[0];
        lat = c[2] ? 32'd21 : 32'd20;
        repeat (30) @(posedge aclk);
        check("lane1_on", 32'(lane1_on), 32'(c[0]));
        watch = 1'b1;
        repeat (40) @(posedge aclk);
        watch = 1'b0;
    endtask : set_ctrl

    // Request, hold and release sync, timing commas and resume
    task automatic sync_run();
        sync_ask <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (comma0 !== 1'b1 && n < 40);
        check("comma delay", 32'(n), 32'd11);
        repeat (20) @(posedge aclk);
        #1;
        check("comma lane0", 32'(comma0), 32'h1);
        check("comma lane1", 32'(comma1), 32'(dual));
        @(posedge aclk);
        sync_ask <= 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (comma0 === 1'b1 && n < 40);
        check("resume delay", 32'(n), 32'd10);
        check("resume high octet", 32'(sample_sent), 32'h1);
        @(posedge aclk);
    endtask : sync_run

    // Power down by register or pin, then time the wake-up
    task automatic wake_run(input logic [1:0] kind, input int exp);
        if (kind == 2'd0) axi_wr(alf_pkg::CTRL_OFF, 32'h8, r);
        else if (kind == 2'd1) pdn_full <= 1'b1;
        else pdn_fast <= 1'b1;
        repeat (10) @(posedge aclk);
        check("valid in power-down", 32'(data_valid), 32'h0);
        if (kind == 2'd0) axi_wr(alf_pkg::CTRL_OFF, 32'h0, r);
        pdn_full <= 1'b0;
        pdn_fast <= 1'b0;
        n = 0;
        while (data_valid !== 1'b1 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        check("wake time", 32'(n >= exp - 4 && n <= exp + 8), 32'h1);
    endtask : wake_run

    // Clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Random samples, each noted with the edge that takes it
    always @(posedge aclk) begin
        cyc = cyc + 32'h1;
        v = lfsr(v);
        sample_in <= v[13:0];
        notes.push_back(alf_note_t'{cyc + 32'h1, v[13:0]});
        if (notes.size() > 64) void'(notes.pop_front());
    end

    // Stream monitor
    always @(posedge aclk) begin
        #1;
        if (lo_due) begin
            check("low octet lane0", 32'(byte0), lo_exp);
            check("single pacing", 32'(sample_sent), 32'h0);
            lo_due = 1'b0;
        end
        if (watch && sample_sent === 1'b1) begin
            while (notes.size() > 1 && notes[0].cyc < cyc - lat) void'(notes.pop_front());
            nt = notes.pop_front();
            w = 32'({fmt ? nt.s[13] : ~nt.s[13], nt.s[12:0], 2'h0});
            check("sample age", nt.cyc, cyc - lat);
            check("high octet", 32'(byte0), 32'(w[15:8]));
            if (dual) check("low octet lane1", 32'(byte1), 32'(w[7:0]));
            else begin
                lo_exp = 32'(w[7:0]);
                lo_due = 1'b1;
            end
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, arvalid, sync_ask, pdn_full, pdn_fast} = 7'h00;
        {awaddr, araddr, wdata} = 40'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        n = 0;
        while (data_valid !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        check("wake after reset", 32'(n >= 248 && n <= 253), 32'h1);
        axi_rd(alf_pkg::CTRL_OFF, d, r);
        check("ctrl reset", d, 32'h0);
        axi_rd(alf_pkg::STAT_OFF, d, r);
        check("status valid", 32'(d[2]), 32'h1);
        axi_wr(alf_pkg::STAT_OFF, 32'h1, r);
        check("read-only write", 32'(r), 32'(alf_pkg::RESP_ERR));
        axi_wr(4'h8, 32'h1, r);
        check("unmapped write", 32'(r), 32'(alf_pkg::RESP_ERR));
        axi_rd(4'hc, d, r);
        check("unmapped read", {d[29:0], r}, 32'(alf_pkg::RESP_ERR));
        check("still single", 32'(lane1_on), 32'h0);
        set_ctrl(4'h0);
        set_ctrl(4'h2);
        set_ctrl(4'h3);
        set_ctrl(4'h7);
        set_ctrl(4'h1);
        sync_run();
        set_ctrl(4'h0);
        sync_run();
        wake_run(2'd0, 500);
        wake_run(2'd1, 2500);
        wake_run(2'd2, 2500);
        tally_and_finish();
    end
endmodule : alf_framer_tb
`default_nettype wire
